// ---- sim/dmcp_sub_model.sv ----
// Purpose: Alternating subchannel on channel B: output, then input, 32 pairs
// Assumes: Shared data lines are pulled up, so a released line reads 1
// Notes: A random gap before each request after the first exercises prompt and slow answers
`timescale 1ns/100ps
module dmcp_sub_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic start,
  input wire dmcp_pkg::dmcp_sub_out_t sub_out,
  input wire logic [5:0] ab_n,
  input wire logic [11:0] bus_n,
  output dmcp_pkg::dmcp_sub_in_t sub_in,
  output logic [11:0] drv_n,
  output logic [11:0] in_word,
  output logic [11:0] out_word,
  output logic done
);
  import dmcp_pkg::*;
  logic req_q, inp_q, gnt_q;
  logic [4:0] addr_q;
  logic [3:0] gap_q;
  // Input flag selects the upper table
  assign sub_in.word_address_lines_n = ~(13'hE00 | {7'h00, inp_q, addr_q});
  assign sub_in.direction_in_n = ~inp_q;
  // Address settles before the request line drops
  assign sub_in.cycle_request_n = ~(req_q && gap_q == 4'h0);
  assign drv_n = sub_out.in_gate_n ? 12'hFFF : ~in_word;
  always @(posedge core_clk) begin
    gnt_q <= sub_out.grant_n;
    if (gap_q != 4'h0) gap_q <= gap_q - 4'h1;
    if (!resetn) begin
      req_q <= 1'b0;
      inp_q <= 1'b0;
      addr_q <= 5'h00;
      done <= 1'b0;
      gap_q <= 4'h0;
      in_word <= 12'h000;
    end else if (start) begin
      req_q <= 1'b1;
      inp_q <= 1'b0;
      addr_q <= 5'h00;
      done <= 1'b0;
    end else begin
      if (!sub_out.grant_n) req_q <= 1'b0;
      if (!sub_out.out_strobe_n) out_word <= ~{bus_n[11:6], ab_n};
      if (sub_out.grant_n && !gnt_q) begin
        gap_q <= 4'(1 + $urandom % 8);
        if (!inp_q) begin
          in_word <= 12'($urandom);
          inp_q <= 1'b1;
          req_q <= 1'b1;
        end else if (addr_q == 5'h1F) begin
          done <= 1'b1;
        end else begin
          addr_q <= addr_q + 5'h01;
          inp_q <= 1'b0;
          req_q <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the two-channel memory cycle stealer
// Assumes: Memory model answers a read one cycle after the strobe
// Notes: Channel A is driven by tasks, channel B by the alternating model
`timescale 1ns/100ps
module tb_top;
  import dmcp_pkg::*;
  logic core_clk = 1'b0, resetn = 1'b0, cpu_running = 1'b1, instr_end = 1'b0;
  logic ie_en = 1'b1, start = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ab_oe, cpu_suspend;
  logic chain, b_done;
  dmcp_sub_in_t a_in, b_in;
  dmcp_sub_out_t a_out, b_out;
  dmcp_mem_t mem_o;
  logic [5:0] ab_n;
  logic [11:0] db_n_o, db_oe, bus_n, a_drv_n, b_drv_n, rdata, a_word, b_word;
  logic [11:0] mem [0:8191];
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  int n_errors = 0, n_compared = 0, a_cnt = 0, b_cnt = 0, a_before_b = 0;
  int hi_run = 99, lo_run = 0, ie_cnt = 0, bo = 0, bi = 0;
  wire g = !(a_out.grant_n && b_out.grant_n);
  always #50 core_clk = ~core_clk;
  assign a_drv_n = a_out.in_gate_n ? 12'hFFF : ~a_word;
  assign bus_n = (db_n_o | ~db_oe) & a_drv_n & b_drv_n;
  dmcp_channel_pair dut (.core_clk(core_clk), .resetn(resetn), .chan_a_in(a_in),
    .chan_b_in(b_in), .chan_a_out(a_out), .chan_b_out(b_out), .io_addr_bus_lines_n_o(ab_n),
    .io_addr_bus_lines_oe(ab_oe), .io_data_bus_lines_n_i(bus_n), .io_data_bus_lines_n_o(db_n_o),
    .io_data_bus_lines_oe(db_oe), .mem_o(mem_o), .mem_rdata(rdata), .cpu_running(cpu_running),
    .instr_end(instr_end), .cpu_suspend(cpu_suspend), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  dmcp_sub_model sub (.core_clk(core_clk), .resetn(resetn), .start(start), .sub_out(b_out),
    .ab_n(ab_n), .bus_n(bus_n), .sub_in(b_in), .drv_n(b_drv_n), .in_word(b_word),
    .out_word(), .done(b_done));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic reg_wr_t(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_chk(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 cmp(reg_rdata, e);
  endtask
  task automatic a_xfer(input logic [12:0] ad, input logic dir_n, input int n, input bit chk);
    int w;
    @(posedge core_clk);
    a_in.word_address_lines_n <= ~ad;
    a_in.direction_in_n <= dir_n;
    a_word <= 12'($urandom);
    @(posedge core_clk);
    a_in.cycle_request_n <= 1'b0;
    w = 0;
    for (int i = 0; i < n; i++) begin
      while (a_out.grant_n !== 1'b0 && w < 900) begin @(posedge core_clk); w++; end
      if (i == 0 && chk) cmp(32'(w <= WAIT_CYC + 3), 32'h1);
      if (i == n - 1) a_in.cycle_request_n <= 1'b1;
      while (a_out.grant_n !== 1'b1 && w < 900) begin @(posedge core_clk); w++; end
    end
    cmp(32'(w < 900), 32'h1);
  endtask
  // Block-transfer subchannel on channel A: set up by its address and count arguments, then counts down
  task automatic a_block(input logic [12:0] ad, input int cnt, input logic dir_n);
    logic [12:0] ba;
    int br, c0;
    logic irq;
    ba = ad;
    br = cnt;
    irq = 1'b0;
    c0 = a_cnt;
    while (!irq) begin
      a_xfer(ba, dir_n, 1, 1'b1);
      ba = ba + 13'h0001;
      br = br - 1;
      if (br == 0) irq = 1'b1;
    end
    repeat (60) @(posedge core_clk);
    cmp(32'(a_cnt - c0), 32'(cnt));
    irq = 1'b0;
  endtask
  always @(posedge core_clk) begin
    ie_cnt <= (ie_cnt == 9) ? 0 : ie_cnt + 1;
    instr_end <= ie_en && ie_cnt == 9;
    if (mem_o.re) rdata <= mem[mem_o.addr];
    if (mem_o.we) mem[mem_o.addr] <= mem_o.wdata;
    if (resetn) begin
      if (mem_o.we && !a_out.grant_n) cmp({mem_o.addr, mem_o.wdata},
        {13'(~a_in.word_address_lines_n), a_word});
      if (mem_o.we && !b_out.grant_n) cmp({mem_o.addr, mem_o.wdata},
        {13'(~b_in.word_address_lines_n), b_word});
      if (!a_out.out_strobe_n) cmp(12'(~{db_n_o[11:6], ab_n}),
        mem[13'(~a_in.word_address_lines_n)]);
      if (!b_out.out_strobe_n) cmp(12'(~{db_n_o[11:6], ab_n}),
        mem[13'(~b_in.word_address_lines_n)]);
      if (!a_out.out_strobe_n || !b_out.out_strobe_n) cmp({ab_oe, db_oe}, 13'h1FC0);
      cmp(a_out.grant_n | b_out.grant_n, 1'b1);
      cmp((a_out.out_strobe_n | (!a_out.grant_n & a_in.direction_in_n)) & (a_out.in_gate_n
        | (!a_out.grant_n & !a_in.direction_in_n)), 1'b1);
      cmp((b_out.out_strobe_n | (!b_out.grant_n & b_in.direction_in_n)) & (b_out.in_gate_n
        | (!b_out.grant_n & !b_in.direction_in_n)), 1'b1);
      cmp(cpu_suspend | !g, 1'b1);
      if (g) begin
        lo_run <= lo_run + 1;
        hi_run <= 0;
        if (lo_run == 0) begin
          chain <= (hi_run == 2);
          if (!a_out.grant_n) a_cnt <= a_cnt + 1;
          else begin
            if (b_cnt == 0) a_before_b <= a_cnt;
            b_cnt <= b_cnt + 1;
            cmp(13'(~b_in.word_address_lines_n), b_in.direction_in_n ?
              13'(13'hE00 + bo) : 13'(13'hE20 + bi));
            if (b_in.direction_in_n) bo <= bo + 1;
            else bi <= bi + 1;
          end
        end
      end else begin
        if (lo_run != 0) cmp(lo_run, chain ? CHAIN_CYC - 2 : SINGLE_CYC - 2);
        cmp({ab_oe, db_oe}, 13'h0000);
        lo_run <= 0;
        hi_run <= hi_run + 1;
      end
    end
  end
  initial begin
    #3000000;
    n_errors++;
    finish_test;
  end
  initial begin
    int w;
    void'($urandom(32'h7F14));
    a_in = '1;
    a_word = 12'h000;
    rdata = 12'h000;
    for (int i = 0; i < 8192; i++) mem[i] = 12'($urandom);
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    reg_chk(CTRL_OFS, 32'h3);
    reg_chk(STAT_OFS, 32'h0);
    reg_wr_t(4'h8, 32'hFFFF_FFFF);
    reg_chk(4'h8, 32'h0);
    reg_chk(CTRL_OFS, 32'h3);
    cpu_running <= 1'b0;
    fork a_xfer(13'h0123, 1'b1, 1, 1'b0); join_none
    repeat (150) @(posedge core_clk);
    cmp(a_cnt, 0);
    cpu_running <= 1'b1;
    wait fork;
    a_xfer(13'h1FFF, 1'b0, 1, 1'b1);
    ie_en <= 1'b0;
    a_xfer(13'h0000, 1'b1, 1, 1'b1);
    ie_en <= 1'b1;
    a_xfer(13'h0456, 1'b0, 3, 1'b1);
    reg_wr_t(CTRL_OFS, 32'h1);
    reg_chk(CTRL_OFS, 32'h1);
    @(posedge core_clk);
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    repeat (200) @(posedge core_clk);
    cmp(b_cnt, 0);
    fork
      a_xfer(13'h0777, 1'b1, 3, 1'b0);
      reg_wr_t(CTRL_OFS, 32'h3);
    join
    w = 0;
    while (b_done !== 1'b1 && w < 9000) begin @(posedge core_clk); w++; end
    a_block(13'h0100, 4, 1'b1);
    a_block(13'h0200, 3, 1'b0);
    repeat (5) @(posedge core_clk);
    cmp(a_before_b, 9);
    cmp(b_cnt, 64);
    finish_test;
  end
endmodule

// ---- verilog/dmcp_channel_pair.sv ----
// Purpose: Two-channel direct memory cycle stealer with subchannel handshake
// Assumes: Memory read data returns the cycle after a read strobe
// Notes: Processor supplies run state and end-of-instruction pulses
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module dmcp_channel_pair (
  input wire logic core_clk,
  input wire logic resetn,
  input wire dmcp_pkg::dmcp_sub_in_t chan_a_in,
  input wire dmcp_pkg::dmcp_sub_in_t chan_b_in,
  output dmcp_pkg::dmcp_sub_out_t chan_a_out,
  output dmcp_pkg::dmcp_sub_out_t chan_b_out,
  output logic [dmcp_pkg::HALF_W-1:0] io_addr_bus_lines_n_o,
  output logic io_addr_bus_lines_oe,
  input wire logic [dmcp_pkg::DATA_W-1:0] io_data_bus_lines_n_i,
  output logic [dmcp_pkg::DATA_W-1:0] io_data_bus_lines_n_o,
  output logic [dmcp_pkg::DATA_W-1:0] io_data_bus_lines_oe,
  output dmcp_pkg::dmcp_mem_t mem_o,
  input wire logic [dmcp_pkg::DATA_W-1:0] mem_rdata,
  input wire logic cpu_running,
  input wire logic instr_end,
  output logic cpu_suspend,
  input wire logic [dmcp_pkg::REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  import dmcp_pkg::*;

  function automatic logic in_win(input logic [PH_W-1:0] ph, input logic [PH_W-1:0] lo,
                                  input logic [PH_W-1:0] hi);
    in_win = (ph >= lo) && (ph <= hi);
  endfunction

  dmcp_state_t state_q;
  logic [PH_W-1:0] phase_q;
  logic [PH_W-1:0] len_q;
  logic [WAIT_W-1:0] wait_q;
  logic sel_b_q;
  logic dir_in_q;
  logic chained_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] dout_q;
  logic [DATA_W-1:0] din_q;
  logic [1:0] ctrl_q;
  logic req_a;
  logic req_b;
  logic any_req;
  logic last;
  logic start;
  logic busy;
  logic grant_c;
  logic drv_c;
  logic strobe_c;
  logic gate_c;
  logic grant_q;
  logic drv_q;
  logic strobe_q;
  logic gate_q;

  assign req_a = !chan_a_in.cycle_request_n && ctrl_q[CTRL_EN_A];
  assign req_b = !chan_b_in.cycle_request_n && ctrl_q[CTRL_EN_B];
  assign any_req = req_a || req_b;
  assign busy = (state_q == ST_XFER);
  assign last = busy && (phase_q == len_q - 6'h01);
  // Idle start at end of instruction, or forced when the wait bound runs out
  assign start = cpu_running && any_req &&
                 ((!busy && (instr_end || (wait_q == WAIT_CYC[WAIT_W-1:0] - 7'h01)))
                  || last);

  // Sequencer
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      phase_q <= '0;
      len_q <= SINGLE_CYC[PH_W-1:0];
      chained_q <= 1'b0;
    end else if (start) begin
      state_q <= ST_XFER;
      phase_q <= '0;
      chained_q <= busy;
      len_q <= busy ? CHAIN_CYC[PH_W-1:0] : SINGLE_CYC[PH_W-1:0];
    end else if (last) begin
      state_q <= ST_IDLE;
      phase_q <= '0;
      chained_q <= 1'b0;
    end else if (busy) begin
      phase_q <= phase_q + 6'h01;
    end
  end

  // Latency guard while a request waits for an instruction boundary
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wait_q <= '0;
    end else if (busy || !any_req || !cpu_running || start) begin
      wait_q <= '0;
    end else begin
      wait_q <= wait_q + 7'h01;
    end
  end

  // Capture of the winning subchannel; channel A wins a tie
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sel_b_q <= 1'b0;
      dir_in_q <= 1'b0;
      addr_q <= '0;
    end else if (start) begin
      sel_b_q <= !req_a;
      dir_in_q <= req_a ? !chan_a_in.direction_in_n : !chan_b_in.direction_in_n;
      addr_q <= req_a ? ~chan_a_in.word_address_lines_n : ~chan_b_in.word_address_lines_n;
    end
  end

  // Phase windows, registered below so every pin comes from a flop
  always_comb begin
    grant_c = busy && !last && (phase_q <= len_q - PH_GNT_END);
    drv_c = busy && !dir_in_q && in_win(phase_q, PH_DRV_ON, len_q - PH_DRV_END);
    strobe_c = busy && !dir_in_q && in_win(phase_q, PH_STB_ON, len_q - PH_STB_END);
    gate_c = busy && dir_in_q && in_win(phase_q, PH_GATE_ON, len_q - PH_GATE_END);
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      grant_q <= 1'b0;
      drv_q <= 1'b0;
      strobe_q <= 1'b0;
      gate_q <= 1'b0;
    end else begin
      grant_q <= grant_c;
      drv_q <= drv_c;
      strobe_q <= strobe_c;
      gate_q <= gate_c;
    end
  end

  // Subchannel pins: each control reaches only the selected subchannel
  always_comb begin
    chan_a_out.grant_n = !(grant_q && !sel_b_q);
    chan_b_out.grant_n = !(grant_q && sel_b_q);
    chan_a_out.out_strobe_n = !(strobe_q && !sel_b_q);
    chan_b_out.out_strobe_n = !(strobe_q && sel_b_q);
    chan_a_out.in_gate_n = !(gate_q && !sel_b_q);
    chan_b_out.in_gate_n = !(gate_q && sel_b_q);
  end

  // Data path: memory read for output, bus sample for input
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      dout_q <= '0;
      din_q <= '0;
    end else begin
      if (busy && !dir_in_q && phase_q == PH_LATCH) begin
        dout_q <= mem_rdata;
      end
      if (busy && dir_in_q && phase_q == len_q - PH_GATE_END) begin
        din_q <= ~io_data_bus_lines_n_i;
      end
    end
  end

  // Memory port; only the addressed word can change
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mem_o <= '0;
    end else begin
      mem_o.addr <= addr_q;
      mem_o.wdata <= din_q;
      mem_o.re <= busy && !dir_in_q && phase_q == PH_RD;
      mem_o.we <= busy && dir_in_q && phase_q == len_q - PH_WR_END;
    end
  end

  // Low six bits on the address lines, high six on data lines 7 to 12
  always_comb begin
    io_addr_bus_lines_n_o = ~dout_q[HALF_W-1:0];
    io_addr_bus_lines_oe = drv_q;
    io_data_bus_lines_n_o = {~dout_q[DATA_W-1:HALF_W], {HALF_W{1'b1}}};
    io_data_bus_lines_oe = {{HALF_W{drv_q}}, {HALF_W{1'b0}}};
  end

  // Program held off for the whole stolen cycle, nothing else touched
  assign cpu_suspend = busy;

  // Register port
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_q <= CTRL_RST;
    end else if (reg_wr && reg_addr == CTRL_OFS) begin
      ctrl_q <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        CTRL_OFS: reg_rdata <= {30'h0, ctrl_q};
        STAT_OFS: reg_rdata <= {28'h0, chained_q, dir_in_q, sel_b_q, busy};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // Checks
  grant_exclusive_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !(!chan_a_out.grant_n && !chan_b_out.grant_n))
    else $error("both grants active");

  strobe_scope_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (!chan_a_out.out_strobe_n || !chan_b_out.out_strobe_n) |->
      (!dir_in_q && grant_q && io_addr_bus_lines_oe))
    else $error("strobe outside granted output");

  gate_scope_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !chan_b_out.in_gate_n |-> (dir_in_q && !chan_b_out.grant_n && chan_a_out.in_gate_n))
    else $error("input gate outside granted input");

  single_length_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (!busy && start) |=> (busy && len_q == 6'h27 && cpu_suspend))
    else $error("lone cycle length wrong");

  chain_length_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (last && start) |=> (busy && phase_q == 6'h00 && len_q == 6'h22))
    else $error("chained cycle not immediate");

  chain_continue_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (last && cpu_running && any_req) |=> busy [*8])
    else $error("held request lost its cycle");

  halted_idle_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (!busy && !cpu_running) |=> !busy)
    else $error("cycle started while halted");

  wait_bound_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (!busy && req_a && cpu_running && $stable(req_a)) |-> ##[0:110] (busy || !req_a))
    else $error("channel A waited too long");

  tie_priority_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (start && req_a && req_b) |=> !sel_b_q ##1 !chan_a_out.grant_n)
    else $error("channel B won a tie");

  out_split_a: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(strobe_q) |-> (({io_data_bus_lines_n_o[DATA_W-1:HALF_W], io_addr_bus_lines_n_o} ==
      ~$past(mem_rdata, 5)) && io_addr_bus_lines_oe && io_data_bus_lines_oe == 12'hFC0))
    else $error("output data not on split lines");

  input_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
    mem_o.we |-> (dir_in_q && $past(gate_q, 2) &&
      mem_o.wdata == ~$past(io_data_bus_lines_n_i, 2)))
    else $error("memory write without input gating");
endmodule

// ---- verilog/dmcp_pkg.sv ----
// Purpose: Shared constants and carriers for the two-channel direct memory path
// Assumes: core_clk at 10 MHz; all pins taken as synchronous logic levels
// Notes: Pin levels keep their active-low sense; names ending in _n are low-true
package dmcp_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SINGLE_NS = 3816;
  localparam int unsigned CHAIN_NS = 3392;
  localparam int unsigned WAIT_NS = 11000;
  localparam int unsigned SINGLE_CYC = (SINGLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CHAIN_CYC = (CHAIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAIT_CYC = WAIT_NS / CLK_PERIOD_NS;
  localparam int unsigned PH_W = 6;
  localparam int unsigned WAIT_W = 7;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 12;
  localparam int unsigned HALF_W = 6;
  // Phase marks within one cycle: ON, RD and LATCH marks counted from the grant decision, END marks back from the cycle end
  localparam logic [PH_W-1:0] PH_RD = 6'h01;
  localparam logic [PH_W-1:0] PH_LATCH = 6'h03;
  localparam logic [PH_W-1:0] PH_GATE_ON = 6'h03;
  localparam logic [PH_W-1:0] PH_DRV_ON = 6'h04;
  localparam logic [PH_W-1:0] PH_STB_ON = 6'h07;
  localparam logic [PH_W-1:0] PH_GNT_END = 6'h03;
  localparam logic [PH_W-1:0] PH_DRV_END = 6'h03;
  localparam logic [PH_W-1:0] PH_GATE_END = 6'h05;
  localparam logic [PH_W-1:0] PH_WR_END = 6'h04;
  localparam logic [PH_W-1:0] PH_STB_END = 6'h06;
  // Register port
  localparam int unsigned REG_AW = 4;
  localparam logic [REG_AW-1:0] CTRL_OFS = 4'h0;
  localparam logic [REG_AW-1:0] STAT_OFS = 4'h4;
  localparam int unsigned CTRL_EN_A = 0;
  localparam int unsigned CTRL_EN_B = 1;
  localparam logic [1:0] CTRL_RST = 2'h3;

  typedef struct packed {
    logic [ADDR_W-1:0] word_address_lines_n;
    logic cycle_request_n;
    logic direction_in_n;
  } dmcp_sub_in_t;

  typedef struct packed {
    logic grant_n;
    logic out_strobe_n;
    logic in_gate_n;
  } dmcp_sub_out_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic we;
    logic re;
  } dmcp_mem_t;

  typedef enum logic {ST_IDLE, ST_XFER} dmcp_state_t;
endpackage
